// ### design/fwd_ctrl_pkg.sv
package fwd_ctrl_pkg;

	// ******************************
	// Register indices (byte address is four times the index)
	// ******************************
	localparam logic [9:0] IDX_OWN_MAC_0    = 10'h0_068;
	localparam logic [9:0] IDX_OWN_MAC_5    = 10'h0_06D;
	localparam logic [9:0] IDX_UNK_MCAST    = 10'h0_084;
	localparam logic [9:0] IDX_UNK_VLAN     = 10'h0_085;
	localparam logic [9:0] IDX_SELF_IPMC    = 10'h0_086;
	localparam logic [9:0] IDX_RATE_TAG     = 10'h0_087;
	localparam int         ADDR_W           = 12;

	// ******************************
	// Field positions and reset values
	// ******************************
	localparam int         FWD_EN_BIT       = 5;
	localparam int         MAP_W            = 5;
	localparam int         SELF_FILT_BIT    = 6;
	localparam int         RL_PERIOD_LSB    = 4;
	localparam int         QUEUE_EGR_BIT    = 3;
	localparam int         TAG_SEL_BIT      = 2;
	localparam logic [1:0] UNK_MCAST_RSVD   = 2'h1;
	localparam logic [1:0] RL_PERIOD_RESET  = 2'h1;
	localparam logic [1:0] RL_PERIOD_16     = 2'h0;
	localparam logic [1:0] RL_PERIOD_64     = 2'h1;
	localparam logic [4:0] MAP_RESET        = 5'h00;
	localparam logic [7:0] MAC_BYTE_RESET   = 8'h00;

	// ******************************
	// AXI responses
	// ******************************
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

	// ******************************
	// Timing
	// ******************************
	localparam longint     CLK_HZ           = 64'd10_000_000;
	localparam longint     PERIOD_A_MS      = 64'd16;
	localparam longint     PERIOD_B_MS      = 64'd64;
	localparam longint     PERIOD_C_MS      = 64'd256;
	localparam longint     MS_PER_S         = 64'd1000;

	localparam int         PORTS            = 5;

	typedef enum logic [1:0] {
		KIND_KNOWN,
		KIND_UNK_MCAST,
		KIND_UNK_IP_MCAST,
		KIND_UNK_VLAN
	} frame_kind_type;

endpackage

// ### design/port_map_decode.sv
`timescale 1ns/1ns
module port_map_decode
	import fwd_ctrl_pkg::*;
#(
	parameter int MAP_WIDTH = 5
) (
	input  wire logic                 enable_i,
	input  wire logic [MAP_WIDTH-1:0] map_i,
	input  wire logic [MAP_WIDTH-1:0] normal_ports_i,
	output logic      [MAP_WIDTH-1:0] ports_o,
	output logic                      supported_o
);
	initial begin
		if (MAP_WIDTH != MAP_W)
			$error("port_map_decode: map width must match the port count");
	end

	// Bit n of the map names port n+1; bit 4 is the processor port
	wire logic [MAP_WIDTH-1:0] thermo;
	assign thermo      = map_i & ~(map_i + 1'b1);
	assign supported_o = (thermo == map_i);
	// Unlisted maps are passed through raw; only thermometer codes are guaranteed
	assign ports_o     = enable_i ? map_i : normal_ports_i;
endmodule

// ### design/unknown_frame_forward_control.sv
`timescale 1ns/1ns
// What this block does
// [R1] Unknown multicast enable applies its port map
// [R2] Non-IP multicast class excludes IP multicast
// [R3] Unknown multicast map: 00000 drop, thermometer ports
// [R4] Unknown VLAN enable applies its port map
// [R5] Unknown VLAN map: 00000 drop, thermometer ports
// [R6] Self-address filter drops own-address frames
// [R7] Filter at egress against own MAC registers
// [R8] Unknown IP multicast enable applies its map
// [R9] Unknown IP multicast map decoded likewise
// [R10] Rate period field selects 16/64/256 ms
// [R11] Bit 3 selects port or queue egress limiting
// [R12] Tag select on: per-egress per-source insert settings
// [R13] Tag select off: each source port's insert bit
// [R14] Map bit n means port n+1
module unknown_frame_forward_control
	import fwd_ctrl_pkg::*;
#(
	parameter int N_PORTS     = 5,
	parameter int PERIOD_A_CY = int'(PERIOD_A_MS * CLK_HZ / MS_PER_S),
	parameter int PERIOD_B_CY = int'(PERIOD_B_MS * CLK_HZ / MS_PER_S),
	parameter int PERIOD_C_CY = int'(PERIOD_C_MS * CLK_HZ / MS_PER_S)
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic [fwd_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [fwd_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         frame_valid_i,
	input  wire fwd_ctrl_pkg::frame_kind_type frame_kind_i,
	input  wire logic [N_PORTS-1:0]           normal_ports_i,
	input  wire logic [47:0]                  dest_mac_i,
	input  wire logic [2:0]                   src_port_i,
	input  wire logic [N_PORTS-1:0]           port_tag_insert_i,
	input  wire logic [N_PORTS*N_PORTS-1:0]   egress_src_insert_i,
	output logic                              fwd_valid_o,
	output logic [N_PORTS-1:0]                fwd_ports_o,
	output logic                              fwd_drop_o,
	output logic                              fwd_map_supported_o,
	output logic [N_PORTS-1:0]                tag_insert_o,
	output logic                              queue_egress_limit_o,
	output logic                              rate_period_tick_o
);
	import fwd_ctrl_pkg::*;

	initial begin
		if (N_PORTS != PORTS)
			$error("unknown_frame_forward_control: only five ports are served");
		if (PERIOD_A_CY < 1 || PERIOD_B_CY < 1 || PERIOD_C_CY < 1)
			$error("unknown_frame_forward_control: periods must be at least one cycle");
	end

	// ******************************
	// Register state
	// ******************************
	logic                 unk_mcast_en;
	logic [MAP_W-1:0]     unk_mcast_map;
	logic                 unk_vlan_en;
	logic [MAP_W-1:0]     unk_vlan_map;
	logic                 self_filt_en;
	logic                 unk_ipmc_en;
	logic [MAP_W-1:0]     unk_ipmc_map;
	logic [1:0]           rl_period;
	logic                 queue_egress;
	logic                 tag_sel_en;
	logic [7:0]           own_mac [6];

	// ******************************
	// AXI4-Lite write channel
	// ******************************
	logic                 aw_held;
	logic                 w_held;
	logic [ADDR_W-1:0]    aw_addr;
	logic [7:0]           w_byte;
	logic                 w_lane0;

	wire logic            aw_take;
	wire logic            w_take;
	wire logic            do_write;
	wire logic [9:0]      wr_idx;
	wire logic            wr_mac;
	wire logic            wr_hit;
	wire logic [7:0]      wr_val;
	wire logic [2:0]      wr_mac_sel;

	assign aw_take    = s_axi_awvalid && s_axi_awready;
	assign w_take     = s_axi_wvalid && s_axi_wready;
	assign do_write   = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx     = aw_addr[ADDR_W-1:2];
	assign wr_mac     = (wr_idx >= IDX_OWN_MAC_0) && (wr_idx <= IDX_OWN_MAC_5);
	assign wr_hit     = wr_mac || (wr_idx >= IDX_UNK_MCAST && wr_idx <= IDX_RATE_TAG);
	assign wr_val     = w_byte;
	assign wr_mac_sel = 3'(wr_idx - IDX_OWN_MAC_0);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_byte        <= '0;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held  <= 1'b1;
				w_byte  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Ready drops after each take and stays low until the write completes, so a held item is never overwritten
			s_axi_awready <= !aw_held && !aw_take && !do_write;
			s_axi_wready  <= !w_held && !w_take && !do_write;
		end
	end

	// ******************************
	// Register writes
	// ******************************
	wire logic            wr_en;
	assign wr_en = do_write && w_lane0;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			unk_mcast_en  <= 1'b0;
			unk_mcast_map <= MAP_RESET;
			unk_vlan_en   <= 1'b0;
			unk_vlan_map  <= MAP_RESET;
			self_filt_en  <= 1'b0;
			unk_ipmc_en   <= 1'b0;
			unk_ipmc_map  <= MAP_RESET;
			rl_period     <= RL_PERIOD_RESET;
			queue_egress  <= 1'b0;
			tag_sel_en    <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				own_mac[i] <= MAC_BYTE_RESET;
			end
		end else if (wr_en) begin
			unique case (wr_idx)
				IDX_UNK_MCAST: begin
					unk_mcast_en  <= wr_val[FWD_EN_BIT];
					unk_mcast_map <= wr_val[MAP_W-1:0];
				end
				IDX_UNK_VLAN: begin
					unk_vlan_en  <= wr_val[FWD_EN_BIT];
					unk_vlan_map <= wr_val[MAP_W-1:0];
				end
				IDX_SELF_IPMC: begin
					self_filt_en <= wr_val[SELF_FILT_BIT];
					unk_ipmc_en  <= wr_val[FWD_EN_BIT];
					unk_ipmc_map <= wr_val[MAP_W-1:0];
				end
				IDX_RATE_TAG: begin
					rl_period    <= wr_val[RL_PERIOD_LSB+:2];
					queue_egress <= wr_val[QUEUE_EGR_BIT];
					tag_sel_en   <= wr_val[TAG_SEL_BIT];
				end
				default: begin
					if (wr_mac)
						own_mac[wr_mac_sel] <= wr_val;
				end
			endcase
		end
	end

	// ******************************
	// AXI4-Lite read channel
	// ******************************
	wire logic            ar_take;
	wire logic [9:0]      rd_idx;
	wire logic            rd_mac;
	wire logic [2:0]      rd_mac_sel;
	wire logic [7:0]      rd_unk_mcast;
	wire logic [7:0]      rd_unk_vlan;
	wire logic [7:0]      rd_self_ipmc;
	wire logic [7:0]      rd_rate_tag;
	logic [7:0]           rd_val;
	logic                 rd_hit;

	assign ar_take      = s_axi_arvalid && s_axi_arready;
	assign rd_idx       = s_axi_araddr[ADDR_W-1:2];
	assign rd_mac       = (rd_idx >= IDX_OWN_MAC_0) && (rd_idx <= IDX_OWN_MAC_5);
	assign rd_mac_sel   = 3'(rd_idx - IDX_OWN_MAC_0);
	assign rd_unk_mcast = {UNK_MCAST_RSVD, unk_mcast_en, unk_mcast_map};
	assign rd_unk_vlan  = {2'b00, unk_vlan_en, unk_vlan_map};
	assign rd_self_ipmc = {1'b0, self_filt_en, unk_ipmc_en, unk_ipmc_map};
	assign rd_rate_tag  = {2'b00, rl_period, queue_egress, tag_sel_en, 2'b00};

	always_comb begin
		rd_hit = 1'b1;
		unique case (rd_idx)
			IDX_UNK_MCAST: rd_val = rd_unk_mcast;
			IDX_UNK_VLAN:  rd_val = rd_unk_vlan;
			IDX_SELF_IPMC: rd_val = rd_self_ipmc;
			IDX_RATE_TAG:  rd_val = rd_rate_tag;
			default: begin
				rd_hit = rd_mac;
				rd_val = rd_mac ? own_mac[rd_mac_sel] : 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_val};
				s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_rvalid && !ar_take;
		end
	end

	// ******************************
	// Unknown-class forwarding decision
	// ******************************
	wire logic [MAP_W-1:0] mcast_ports;
	wire logic [MAP_W-1:0] vlan_ports;
	wire logic [MAP_W-1:0] ipmc_ports;
	wire logic             mcast_ok;
	wire logic             vlan_ok;
	wire logic             ipmc_ok;

	// Maps decode as port sets; all-zero yields an empty set, a drop [R3] [R5] [R9] [R14]
	port_map_decode #(.MAP_WIDTH(MAP_W)) mcast_dec (
		.enable_i       (unk_mcast_en),                 // [R1]
		.map_i          (unk_mcast_map),
		.normal_ports_i (normal_ports_i),
		.ports_o        (mcast_ports),
		.supported_o    (mcast_ok)
	);
	port_map_decode #(.MAP_WIDTH(MAP_W)) vlan_dec (
		.enable_i       (unk_vlan_en),                  // [R4]
		.map_i          (unk_vlan_map),
		.normal_ports_i (normal_ports_i),
		.ports_o        (vlan_ports),
		.supported_o    (vlan_ok)
	);
	port_map_decode #(.MAP_WIDTH(MAP_W)) ipmc_dec (
		.enable_i       (unk_ipmc_en),                  // [R8]
		.map_i          (unk_ipmc_map),
		.normal_ports_i (normal_ports_i),
		.ports_o        (ipmc_ports),
		.supported_o    (ipmc_ok)
	);

	logic [N_PORTS-1:0]   class_ports;
	logic                 class_ok;

	// IP multicast never takes the non-IP map [R2]
	always_comb begin
		unique case (frame_kind_i)
			KIND_UNK_MCAST: begin
				class_ports = mcast_ports;
				class_ok    = mcast_ok || !unk_mcast_en;
			end
			KIND_UNK_IP_MCAST: begin
				class_ports = ipmc_ports;
				class_ok    = ipmc_ok || !unk_ipmc_en;
			end
			KIND_UNK_VLAN: begin
				class_ports = vlan_ports;
				class_ok    = vlan_ok || !unk_vlan_en;
			end
			default: begin
				class_ports = normal_ports_i;
				class_ok    = 1'b1;
			end
		endcase
	end

	// Own-address check clears the egress set, after forwarding chose it [R6] [R7]
	wire logic [47:0]        own_addr;
	wire logic               to_self;
	wire logic [N_PORTS-1:0] next_ports;

	assign own_addr   = {own_mac[0], own_mac[1], own_mac[2],
	                     own_mac[3], own_mac[4], own_mac[5]};
	assign to_self    = self_filt_en && (dest_mac_i == own_addr);   // [R6]
	assign next_ports = to_self ? '0 : class_ports;                 // [R7]

	// ******************************
	// Tag insertion selection
	// ******************************
	logic [N_PORTS-1:0]   next_tag;

	always_comb begin
		for (int e = 0; e < N_PORTS; e++) begin
			if (tag_sel_en)
				next_tag[e] = egress_src_insert_i[e*N_PORTS + int'(src_port_i)];  // [R12]
			else
				next_tag[e] = port_tag_insert_i[src_port_i];                     // [R13]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fwd_valid_o         <= 1'b0;
			fwd_ports_o         <= '0;
			fwd_drop_o          <= 1'b0;
			fwd_map_supported_o <= 1'b1;
			tag_insert_o        <= '0;
		end else begin
			fwd_valid_o <= frame_valid_i;
			if (frame_valid_i) begin
				fwd_ports_o         <= next_ports;
				fwd_drop_o          <= (next_ports == '0);
				fwd_map_supported_o <= class_ok;
				tag_insert_o        <= next_tag;
			end
		end
	end

	// ******************************
	// Rate-limit unit period and egress scheme
	// ******************************
	localparam int CNT_W = $clog2(PERIOD_C_CY + 1);
	logic [CNT_W-1:0]     period_cnt;
	wire logic [CNT_W-1:0] period_last;

	assign period_last = (rl_period == RL_PERIOD_16) ? CNT_W'(PERIOD_A_CY - 1) :
	                     (rl_period == RL_PERIOD_64) ? CNT_W'(PERIOD_B_CY - 1) :
	                                                   CNT_W'(PERIOD_C_CY - 1);  // [R10]

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			period_cnt           <= '0;
			rate_period_tick_o   <= 1'b0;
			queue_egress_limit_o <= 1'b0;
		end else begin
			// A shortened period restarts cleanly instead of running to wrap
			if (period_cnt >= period_last) begin
				period_cnt         <= '0;
				rate_period_tick_o <= 1'b1;                                 // [R10]
			end else begin
				period_cnt         <= period_cnt + 1'b1;
				rate_period_tick_o <= 1'b0;
			end
			queue_egress_limit_o <= queue_egress;                           // [R11]
		end
	end
endmodule

// ### verif/fwd_ctrl_chk.sv
`timescale 1ns/1ns
module fwd_ctrl_chk
	import fwd_ctrl_pkg::*;
(
	input wire logic                         clk_i,
	input wire logic                         rst_n_i,
	input wire logic                         s_axi_arvalid,
	input wire logic                         s_axi_arready,
	input wire logic                         s_axi_rvalid,
	input wire logic                         s_axi_bvalid,
	input wire logic                         frame_valid_i,
	input wire fwd_ctrl_pkg::frame_kind_type frame_kind_i,
	input wire logic [4:0]                   normal_ports_i,
	input wire logic                         fwd_valid_o,
	input wire logic [4:0]                   fwd_ports_o,
	input wire logic                         fwd_drop_o,
	input wire logic                         fwd_map_supported_o,
	input wire logic                         queue_egress_limit_o,
	input wire logic                         rate_period_tick_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ****************
	// Properties
	// ****************
	property p_frame_lat; frame_valid_i |=> fwd_valid_o; endproperty
	a_frame_lat: assert property (p_frame_lat) else $error("no decision after frame");
	property p_no_spur; !frame_valid_i |=> !fwd_valid_o; endproperty
	a_no_spur: assert property (p_no_spur) else $error("decision without frame");
	property p_drop_flag; fwd_valid_o |-> (fwd_drop_o == (fwd_ports_o == 5'h00)); endproperty
	a_drop_flag: assert property (p_drop_flag) else $error("drop flag disagrees");
	property p_known;
		frame_valid_i && frame_kind_i == KIND_KNOWN
			|=> (fwd_ports_o & ~$past(normal_ports_i)) == 5'h00 && fwd_map_supported_o;
	endproperty
	a_known: assert property (p_known) else $error("known frame spread");
	property p_tick_gap; rate_period_tick_o |=> !rate_period_tick_o [*3]; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	// Mode flag may only move as a register write completes
	property p_queue_src;
		$changed(queue_egress_limit_o) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_queue_src: assert property (p_queue_src) else $error("queue mode moved alone");
	property p_read_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_read_resp: assert property (p_read_resp) else $error("read not answered");
	property p_unsup;
		fwd_valid_o && !fwd_map_supported_o |-> fwd_drop_o || !(fwd_ports_o inside
			{5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F});
	endproperty
	a_unsup: assert property (p_unsup) else $error("listed map flagged odd");

	c_drop: cover property (fwd_valid_o && fwd_drop_o);
	c_tick: cover property (rate_period_tick_o);
	c_queue: cover property ($rose(queue_egress_limit_o));
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
	import fwd_ctrl_pkg::*;
	logic           clk_i = 1'b0;
	logic           rst_n_i = 1'b0;
	logic [11:0]    awaddr = 12'h000, araddr = 12'h000;
	logic [31:0]    wdata = 32'h0000_0000, rdata;
	logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic           rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [1:0]     bresp, rresp;
	logic           fv = 1'b0, fvo, drop, sup, queue, tick;
	frame_kind_type kind = KIND_KNOWN;
	logic [4:0]     normal = 5'h00, tins = 5'h00, ports, tag;
	logic [47:0]    mac = 48'h0000_0000_0000, dmac = 48'h0000_0000_0000;
	logic [2:0]     src = 3'h0;
	logic [24:0]    esi = 25'h000_0000;
	logic [3:0]     strb = 4'h1;
	int             mismatches = 0, total_checks = 0;

	unknown_frame_forward_control #(.PERIOD_A_CY(4), .PERIOD_B_CY(8), .PERIOD_C_CY(16))
	u_unknown_frame_forward_control (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.frame_valid_i(fv), .frame_kind_i(kind), .normal_ports_i(normal),
		.dest_mac_i(mac), .src_port_i(src), .port_tag_insert_i(tins),
		.egress_src_insert_i(esi), .fwd_valid_o(fvo), .fwd_ports_o(ports),
		.fwd_drop_o(drop), .fwd_map_supported_o(sup), .tag_insert_o(tag),
		.queue_egress_limit_o(queue), .rate_period_tick_o(tick)
	);

	always #50 clk_i = ~clk_i;

	// ****************
	// Shared tasks
	// ****************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
		if (n == 50) mismatches++;
	endtask

	task rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		chk(rdata, {24'h00_0000, e});
		chk(32'(rresp), 32'(er));
		if (n == 50) mismatches++;
	endtask

	task frame(input frame_kind_type k, input logic [4:0] np, input logic [4:0] ep,
		input logic [2:0] s);
		@(posedge clk_i);
		fv <= 1'b1;
		kind <= k;
		normal <= np;
		src <= s;
		mac <= dmac;
		@(posedge clk_i);
		fv <= 1'b0;
		#1;
		chk(32'(fvo), 32'h0000_0001);
		chk(32'(ports), 32'(ep));
		chk(32'(drop), 32'(ep == 5'h00));
	endtask

	task gap(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!tick && n < 100);
	endtask

	// ****************
	// Scenarios
	// ****************
	task t_reset;
		rd(IDX_UNK_MCAST, 8'h40, RESP_OKAY);
		rd(IDX_UNK_VLAN, 8'h00, RESP_OKAY);
		rd(IDX_SELF_IPMC, 8'h00, RESP_OKAY);
		rd(IDX_RATE_TAG, 8'h10, RESP_OKAY);
		rd(IDX_OWN_MAC_5, 8'h00, RESP_OKAY);
		rd(10'h3FF, 8'h00, RESP_SLVERR);
		wr(10'h3FF, 8'hFF, RESP_SLVERR);
		chk(32'(queue), 32'h0000_0000);
		// Low byte lane off: the write is answered but leaves the register alone
		strb <= 4'h0;
		wr(IDX_UNK_VLAN, 8'h3F, RESP_OKAY);
		strb <= 4'h1;
		rd(IDX_UNK_VLAN, 8'h00, RESP_OKAY);
	endtask

	task t_maps;
		logic [9:0]     ix [3] = '{IDX_UNK_MCAST, IDX_UNK_VLAN, IDX_SELF_IPMC};
		frame_kind_type kd [3] = '{KIND_UNK_MCAST, KIND_UNK_VLAN, KIND_UNK_IP_MCAST};
		logic [4:0]     cd [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F};
		for (int c = 0; c < 3; c++) begin
			for (int m = 0; m < 6; m++) begin
				wr(ix[c], {3'b001, cd[m]}, RESP_OKAY);
				rd(ix[c], {1'b0, c == 0, 1'b1, cd[m]}, RESP_OKAY);
				frame(kd[c], 5'h0A, cd[m], 3'h0);
				chk(32'(sup), 32'h0000_0001);
			end
			wr(ix[c], 8'h1F, RESP_OKAY);
			frame(kd[c], 5'h0A, 5'h0A, 3'h0);
		end
		wr(IDX_UNK_MCAST, 8'h20, RESP_OKAY);
		frame(KIND_UNK_IP_MCAST, 5'h0A, 5'h0A, 3'h1);
		frame(KIND_UNK_MCAST, 5'h0A, 5'h00, 3'h1);
		wr(IDX_UNK_VLAN, 8'h25, RESP_OKAY);
		frame(KIND_UNK_VLAN, 5'h0A, 5'h05, 3'h1);
		chk(32'(sup), 32'h0000_0000);
		frame(KIND_KNOWN, 5'h13, 5'h13, 3'h1);
	endtask

	task t_self;
		logic [47:0] own;
		own = 48'h0211_2233_4455;
		for (int i = 0; i < 6; i++) wr(IDX_OWN_MAC_0 + 10'(i), own[47-8*i -: 8], RESP_OKAY);
		wr(IDX_SELF_IPMC, 8'h40, RESP_OKAY);
		dmac = own;
		frame(KIND_KNOWN, 5'h1F, 5'h00, 3'h0);
		dmac = own ^ 48'h0000_0000_0001;
		frame(KIND_KNOWN, 5'h1F, 5'h1F, 3'h0);
		wr(IDX_SELF_IPMC, 8'h00, RESP_OKAY);
		dmac = own;
		frame(KIND_KNOWN, 5'h1F, 5'h1F, 3'h0);
	endtask

	task t_rate;
		int n;
		int exp [4] = '{4, 8, 16, 16};
		for (int p = 0; p < 4; p++) begin
			wr(IDX_RATE_TAG, {2'b00, 2'(p), 4'h0}, RESP_OKAY);
			gap(n);
			gap(n);
			gap(n);
			chk(32'(n), 32'(exp[p]));
		end
	endtask

	task t_queue;
		wr(IDX_RATE_TAG, 8'h18, RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk(32'(queue), 32'h0000_0001);
		wr(IDX_RATE_TAG, 8'h10, RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk(32'(queue), 32'h0000_0000);
	endtask

	task t_tag;
		@(posedge clk_i);
		tins <= 5'h04;
		esi <= 25'h002_0004;
		frame(KIND_KNOWN, 5'h1F, 5'h1F, 3'h2);
		chk(32'(tag), 32'h0000_001F);
		frame(KIND_KNOWN, 5'h1F, 5'h1F, 3'h1);
		chk(32'(tag), 32'h0000_0000);
		wr(IDX_RATE_TAG, 8'h14, RESP_OKAY);
		frame(KIND_KNOWN, 5'h1F, 5'h1F, 3'h2);
		chk(32'(tag), 32'h0000_0009);
		frame(KIND_KNOWN, 5'h1F, 5'h1F, 3'h1);
		chk(32'(tag), 32'h0000_0000);
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset;
		t_maps;
		t_self;
		t_rate;
		t_queue;
		t_tag;
		conclude;
	end

	// Generous: the whole sequence needs only a few hundred cycles
	initial begin
		#3_000_000;
		mismatches++;
		conclude;
	end
endmodule

bind unknown_frame_forward_control fwd_ctrl_chk u_fwd_ctrl_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
	.frame_valid_i(frame_valid_i), .frame_kind_i(frame_kind_i),
	.normal_ports_i(normal_ports_i), .fwd_valid_o(fwd_valid_o), .fwd_ports_o(fwd_ports_o),
	.fwd_drop_o(fwd_drop_o), .fwd_map_supported_o(fwd_map_supported_o),
	.queue_egress_limit_o(queue_egress_limit_o), .rate_period_tick_o(rate_period_tick_o)
);
